// ==== include/sflash_cfg.svh ====
// Constants of the serial flash command front end.
// Assumes inclusion by bare name from the package and the design.
`ifndef SFLASH_CFG_SVH
`define SFLASH_CFG_SVH

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_RD1 8'h05
`define OP_STATUS_RD2 8'h35
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7A
`define OP_PAGE_PROG 8'h02
`define OP_SECT_ERASE 8'h20
`define OP_BLK32_ERASE 8'h52
`define OP_BLK64_ERASE 8'hD8
`define OP_CHIP_ERASE_A 8'h60
`define OP_CHIP_ERASE_B 8'hC7

// ----------------------------------------
// Status bit positions and sizes
// ----------------------------------------
`define ST_BUSY 0
`define ST_WRITE_LATCH 1
`define ST_BP_LO 2
`define ST_QUAD 6
`define ST_LOCK 7
`define ST_SUSPEND 8
`define BYTE_BITS 8
`define ADDR_BYTES 3'h4
`define BLOCKS 8'h80
`define BP_RESET 4'h0

`endif

// ==== include/sflash_pkg.sv ====
// Types shared by the serial flash front end.
// Assumes sflash_cfg.svh is on the include path.
`include "sflash_cfg.svh"

package sflash_pkg;

  // Array operation handed to the program/erase engine
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] addr;
  } cmd_t;

  typedef enum logic [2:0] {
    K_WEN_SET,
    K_WEN_CLR,
    K_STAT_WR,
    K_SUSP,
    K_RESM,
    K_ADDR,
    K_CHIP,
    K_OTHER
  } kind_t;

endpackage

// ==== rtl/sflash_front.sv ====
// Command front end of a serial flash, on the memory side.
// Assumes all link pins are asynchronous to clk; busy_in and cmd_ready
// come from the array engine on clk.
//
// What this block does
// - Pin protect low and lock set: lock and area bits cannot change.
// - Pin protect high: lock bit has no effect on status writes.
// - Suspend instruction sets the suspend flag.
// - Resume instruction or power cycle clears the suspend flag.
// - Pause entered with select low, at a clock low level.
// - Pause left only when the serial clock is low.
// - Paused: output floats, input and clock ignored.
// - Select high during pause resets the interface.
// - Pause lasts while the pause pin is low.
// - Quad enable disables pause; pin becomes data line 3.
// - Quad enable disables write protect; pin becomes data line 2.
// - Status write refused with pin low and lock set, or with the write enable latch clear.
// - Every bus cycle is exactly eight bits.
// - Instruction starts at select fall; bits taken on rise, MSB first.
// - Select rise inside a bus cycle aborts the instruction.
// - Write enable latch clear: program and erase ignored.
// - Area bits select protected 64KB blocks; writes there blocked.
// - Quad enable 0 keeps pin functions; 1 makes them data lines.
// - Busy bit is 1 while program or erase runs.
`timescale 1ns/10ps
`default_nettype none
`include "sflash_cfg.svh"

module sflash_front (
  input wire logic clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic data_line_2,
  input wire logic data_line_3,
  output logic so,
  output logic so_oe_n,
  output logic [15:0] status,
  input wire logic busy_in,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output sflash_pkg::cmd_t cmd_data
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic cs_n_s, sck_s, si_s, wp_s, hold_s;
  logic cs_d_r, sck_d_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 5'h19;
      sync2_r <= 5'h19;
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      sync1_r <= {data_line_3, data_line_2, si, sck, cs_n};
      sync2_r <= sync1_r;
      cs_d_r <= cs_n_s;
      sck_d_r <= sck_s;
    end
  end

  assign cs_n_s = sync2_r[0];
  assign sck_s = sync2_r[1];
  assign si_s = sync2_r[2];
  assign wp_s = sync2_r[3];
  assign hold_s = sync2_r[4];

  // ----------------------------------------
  // Status state
  // ----------------------------------------
  logic [3:0] bp_r;
  logic quad_r, lock_r, wen_r, suspend_r, hold_r;
  logic locked, busy, sck_rise, sck_fall, cs_rise, exec_go;

  // Protect pin only counts in standard and dual modes
  assign locked = !quad_r && !wp_s && lock_r;
  assign sck_rise = sck_s && !sck_d_r && !cs_n_s && !hold_r;
  assign sck_fall = !sck_s && sck_d_r && !cs_n_s && !hold_r;
  assign cs_rise = cs_n_s && !cs_d_r;

  // ----------------------------------------
  // Pause
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_r <= 1'b0;
    end else if (cs_n_s || quad_r) begin
      hold_r <= 1'b0;
    end else if (!sck_s) begin
      hold_r <= !hold_s;
    end
  end

  // ----------------------------------------
  // Bit and byte framing
  // ----------------------------------------
  logic [7:0] shift_r, op_r, byte_w;
  logic [23:0] arg_r;
  logic [2:0] bitcnt_r, bytecnt_r;
  logic reading_r, sel2_r;

  assign byte_w = {shift_r[6:0], si_s};

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_r <= 8'h00;
      op_r <= 8'h00;
      arg_r <= 24'h000000;
      bitcnt_r <= 3'h0;
      bytecnt_r <= 3'h0;
      reading_r <= 1'b0;
      sel2_r <= 1'b0;
    end else if (cs_n_s) begin
      bitcnt_r <= 3'h0;
      reading_r <= 1'b0;
      if (!cs_rise) begin
        bytecnt_r <= 3'h0;
      end
    end else if (sck_rise) begin
      shift_r <= byte_w;
      bitcnt_r <= bitcnt_r + 3'h1;
      if (bitcnt_r == 3'h7) begin
        if (bytecnt_r != 3'h7) begin
          bytecnt_r <= bytecnt_r + 3'h1;
        end
        if (bytecnt_r == 3'h0) begin
          op_r <= byte_w;
          reading_r <= byte_w == `OP_STATUS_RD1 ||
            byte_w == `OP_STATUS_RD2;
          sel2_r <= byte_w == `OP_STATUS_RD2;
        end else if (bytecnt_r < `ADDR_BYTES) begin
          arg_r <= {arg_r[15:0], byte_w};
        end
      end
    end
  end

  // Whole, non-empty frames only: an empty one would replay the old opcode
  assign exec_go = cs_rise && !hold_r && bitcnt_r == 3'h0 &&
    bytecnt_r != 3'h0;

  // ----------------------------------------
  // Instruction decode and protection
  // ----------------------------------------
  sflash_pkg::kind_t kind;

  always_comb begin
    unique case (op_r)
      `OP_WRITE_ENABLE: kind = sflash_pkg::K_WEN_SET;
      `OP_WRITE_DISABLE: kind = sflash_pkg::K_WEN_CLR;
      `OP_STATUS_WRITE: kind = sflash_pkg::K_STAT_WR;
      `OP_SUSPEND: kind = sflash_pkg::K_SUSP;
      `OP_RESUME: kind = sflash_pkg::K_RESM;
      `OP_PAGE_PROG, `OP_SECT_ERASE, `OP_BLK32_ERASE,
      `OP_BLK64_ERASE: kind = sflash_pkg::K_ADDR;
      `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: kind = sflash_pkg::K_CHIP;
      default: kind = sflash_pkg::K_OTHER;
    endcase
  end

  function automatic logic prot_hit(input logic [3:0] bp,
                                    input logic [6:0] blk);
    logic [7:0] b;
    b = {1'b0, blk};
    unique case (bp)
      4'h0: prot_hit = 1'b0;
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
        prot_hit = b >= (`BLOCKS - (8'h01 << bp));
      4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE:
        prot_hit = b < (`BLOCKS - (8'h40 >> (bp - 4'h9)));
      default: prot_hit = 1'b1;
    endcase
  endfunction

  logic room, push, pop, addr_ok, chip_ok;
  logic stat_wr_go;
  sflash_pkg::cmd_t push_d;

  assign addr_ok = kind == sflash_pkg::K_ADDR &&
    bytecnt_r >= `ADDR_BYTES && !prot_hit(bp_r, arg_r[22:16]);
  assign chip_ok = kind == sflash_pkg::K_CHIP && bytecnt_r == 3'h1 &&
    bp_r == 4'h0;
  assign push = exec_go && wen_r && room && (addr_ok || chip_ok);
  assign push_d = '{op: op_r, addr: arg_r};
  assign stat_wr_go = exec_go && kind == sflash_pkg::K_STAT_WR &&
    bytecnt_r >= 3'h2;

  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bp_r <= `BP_RESET;
      quad_r <= 1'b0;
      lock_r <= 1'b0;
      wen_r <= 1'b0;
      suspend_r <= 1'b0;
    end else if (exec_go) begin
      unique case (kind)
        sflash_pkg::K_WEN_SET: wen_r <= bytecnt_r == 3'h1;
        sflash_pkg::K_WEN_CLR: wen_r <= 1'b0;
        sflash_pkg::K_STAT_WR: begin
          // Status write also needs the latch set first
          if (stat_wr_go && wen_r && !locked) begin
            bp_r <= arg_r[`ST_QUAD-1:`ST_BP_LO];
            quad_r <= arg_r[`ST_QUAD];
            lock_r <= arg_r[`ST_LOCK];
          end
          if (stat_wr_go) begin
            wen_r <= 1'b0;
          end
        end
        sflash_pkg::K_SUSP: suspend_r <= 1'b1;
        sflash_pkg::K_RESM: suspend_r <= 1'b0;
        sflash_pkg::K_ADDR, sflash_pkg::K_CHIP: begin
          if (push) begin
            wen_r <= 1'b0;
          end
        end
        sflash_pkg::K_OTHER: wen_r <= wen_r;
      endcase
    end
  end

  // Queued work counts as busy so a poll never sees a gap
  assign busy = busy_in || cmd_valid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status <= 16'h0000;
    end else begin
      status <= {7'h00, suspend_r, lock_r, quad_r, bp_r, wen_r, busy};
    end
  end

  // ----------------------------------------
  // Serial output
  // ----------------------------------------
  logic [7:0] out_byte;
  logic out_on_r;
  assign out_byte = sel2_r ? status[15:8] : status[7:0];

  // Output that has begun is driven again once a pause ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      so <= 1'b0;
      so_oe_n <= 1'b1;
      out_on_r <= 1'b0;
    end else if (cs_n_s || hold_r) begin
      so_oe_n <= 1'b1;
      out_on_r <= out_on_r && !cs_n_s;
    end else if (sck_fall && reading_r) begin
      so <= out_byte[~bitcnt_r];
      so_oe_n <= 1'b0;
      out_on_r <= 1'b1;
    end else begin
      so_oe_n <= !out_on_r;
    end
  end

  // ----------------------------------------
  // Two-entry command buffer
  // ----------------------------------------
  logic v1_r;
  sflash_pkg::cmd_t e1_r;

  assign room = !v1_r;
  assign pop = cmd_valid && cmd_ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_valid <= 1'b0;
      v1_r <= 1'b0;
      cmd_data <= '0;
      e1_r <= '0;
    end else if (pop) begin
      cmd_valid <= v1_r || push;
      cmd_data <= v1_r ? e1_r : push_d;
      v1_r <= v1_r && push;
      e1_r <= push_d;
    end else if (push && !cmd_valid) begin
      cmd_valid <= 1'b1;
      cmd_data <= push_d;
    end else if (push) begin
      v1_r <= 1'b1;
      e1_r <= push_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  chk_lock_refuse: assert property (
    stat_wr_go && locked |=> $stable(bp_r) && $stable(lock_r))
    else $error("locked status write changed protect bits");
  chk_wp_ignore: assert property (
    stat_wr_go && wen_r && wp_s && !quad_r |=>
      bp_r == $past(arg_r[5:2]) && lock_r == $past(arg_r[7]))
    else $error("status write refused with protect pin high");
  chk_susp_set: assert property (
    exec_go && kind == sflash_pkg::K_SUSP |=> ##1 status[`ST_SUSPEND])
    else $error("suspend flag not set");
  chk_resume_clr: assert property (
    exec_go && kind == sflash_pkg::K_RESM |=> ##1 !status[`ST_SUSPEND])
    else $error("suspend flag not cleared");
  chk_pause_float: assert property (
    hold_r |=> so_oe_n)
    else $error("output driven while paused");
  chk_pause_cs: assert property (
    cs_n_s |=> !hold_r && bitcnt_r == 3'h0)
    else $error("interface not reset by select high");
  chk_quad_nopause: assert property (
    quad_r && !hold_r |=> !hold_r)
    else $error("pause entered in quad mode");
  chk_latch_gate: assert property (
    exec_go && !wen_r |=> !$rose(v1_r) && !$rose(cmd_valid))
    else $error("array command queued without write enable");
  chk_pause_exit: assert property (
    hold_r && sck_s && !cs_n_s |=> hold_r)
    else $error("pause left while clock high");

  cov_status_read: cover property (sck_fall && reading_r);
  cov_pause: cover property ($rose(hold_r));
  cov_buffer_full: cover property (v1_r && !cmd_ready);
  cov_status_write: cover property (stat_wr_go && wen_r && !locked);

endmodule
`default_nettype wire

// ==== tb/host_spi_model.sv ====
// Host SPI controller model, mode 0, MSB first, for the flash front end.
// Assumes the front end samples these pins on its own faster clock.
`timescale 1ns/10ps
`default_nettype none

module host_spi_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic wp_n,
  output logic pause_n,
  input wire logic so,
  input wire logic so_oe_n
);
  logic pause_oe;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    wp_n = 1'b1;
    pause_n = 1'b1;
    pause_oe = 1'b0;
  end

  task automatic pins(input logic wp);
    wp_n = wp;
  endtask

  // ----------------------------------------
  // One framed command
  // ----------------------------------------
  // nb not a byte multiple aborts; pz picks the bit that is paused
  task automatic cmd(input logic [31:0] w, input int nb, input int pz,
                     output logic [7:0] q);
    cs_n = 1'b0;
    #125;
    for (int i = nb - 1; i >= 0; i--) begin
      si = w[i];
      if (i == pz) begin
        pause_n = 1'b0;
        repeat (2) begin
          #62.5 sck = 1'b1;
          si = ~si;
          #62.5 sck = 1'b0;
        end
        pause_oe = so_oe_n;
        pause_n = 1'b1;
        si = w[i];
      end
      #62.5 sck = 1'b1;
      q = {q[6:0], so};
      #62.5 sck = 1'b0;
    end
    #125 cs_n = 1'b1;
    // Released line shows no stale level
    si = ~si;
    #500;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_sflash_front.sv ====
// Testbench of the serial flash command front end.
// Assumes host_spi_model drives the link pins asynchronously to clk.
`timescale 1ns/10ps
`default_nettype none

module tb_sflash_front;
  logic clk, reset, busy_in, cmd_ready, cs_n, sck, si, wp_n, pause_n;
  logic so, so_oe_n, cmd_valid;
  logic [15:0] status;
  logic [7:0] q;
  sflash_pkg::cmd_t cmd_data;
  logic [31:0] exp_q [2];
  int error_cnt, check_count, n;

  sflash_front uut (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
    .si(si), .data_line_2(wp_n), .data_line_3(pause_n), .so(so),
    .so_oe_n(so_oe_n), .status(status), .busy_in(busy_in),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_data(cmd_data));
  host_spi_model m (.cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .pause_n(pause_n), .so(so), .so_oe_n(so_oe_n));

  always #4 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic op(input logic [31:0] w, input int nb);
    m.cmd(w, nb, -1, q);
  endtask

  task automatic stat_write(input logic [7:0] d);
    op(32'h06, 8);
    op({16'h0, 8'h01, d}, 16);
  endtask

  // Hang guard, well above the normal run time
  initial begin
    #500000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    clk = 1'b0;
    reset = 1'b1;
    busy_in = 1'b0;
    cmd_ready = 1'b0;
    error_cnt = 0;
    check_count = 0;
    exp_q = '{32'h02010203, 32'h20020000};
    repeat (4) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    #1 check({so_oe_n, cmd_valid, status}, 32'h20000);
    // ----------------------------------------
    // Framing and protection
    // ----------------------------------------
    op(32'h06, 8);
    check(status, 16'h0002);
    op(32'h01F, 12);
    check(status, 16'h0002);
    stat_write(8'h84);
    check(status, 16'h0084);
    m.pins(1'b0);
    stat_write(8'h00);
    check(status, 16'h0084);
    m.pins(1'b1);
    stat_write(8'h04);
    check(status, 16'h0004);
    $display("test protect done");
    // ----------------------------------------
    // Array commands and buffer
    // ----------------------------------------
    op(32'h06, 8);
    op(32'h027E0000, 32);
    op(32'h60, 8);
    check({cmd_valid, status}, 32'h00006);
    op(32'h04, 8);
    op(32'h02000000, 32);
    check({cmd_valid, status}, 32'h00004);
    op(32'h06, 8);
    op(32'h02010203, 32);
    op(32'h06, 8);
    op(32'h20020000, 32);
    op(32'h06, 8);
    op(32'hD8030000, 32);
    check({cmd_valid, status}, 32'h10007);
    @(posedge clk);
    foreach (exp_q[k]) begin
      #1 n = 0;
      while (n < 50 && cmd_valid !== 1'b1) begin
        @(posedge clk);
        #1 n++;
      end
      if (n == 50) begin
        error_cnt++;
        give_verdict();
      end
      check(cmd_data, exp_q[k]);
      cmd_ready = 1'b1;
      @(posedge clk);
      #1 cmd_ready = 1'b0;
      @(posedge clk);
    end
    #1 busy_in = 1'b1;
    repeat (3) @(posedge clk);
    #1 check({cmd_valid, status}, 32'h00007);
    busy_in = 1'b0;
    $display("test buffer done");
    // ----------------------------------------
    // Suspend, pause and quad
    // ----------------------------------------
    op(32'h75, 8);
    check(status[8], 1'b1);
    m.cmd(32'h3500, 16, -1, q);
    check(q, 8'h01);
    op(32'h7A, 8);
    check(status[8], 1'b0);
    op(32'h04, 8);
    m.cmd(32'h0500, 16, 4, q);
    check(q, 8'h04);
    check(m.pause_oe, 1'b1);
    stat_write(8'hC4);
    m.cmd(32'h0500, 16, 4, q);
    check(m.pause_oe, 1'b0);
    m.pins(1'b0);
    stat_write(8'h00);
    check(status, 16'h0000);
    op(32'h06, 8);
    op(32'hC7, 8);
    check({cmd_valid, cmd_data.op, status}, 32'h01C70001);
    $display("test pause done");
    give_verdict();
  end
endmodule
`default_nettype wire
